//--- inc/esbc_pkg.sv
// Shared constants and types for the error status and bus config block.
// Assumes a 32-bit APB slave on one clock; byte addresses below.
package esbc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_ERR_EN   = 8'h00;
  localparam logic [7:0] OFS_ERR_LAT  = 8'h04;
  localparam logic [7:0] OFS_ERR_CLR  = 8'h08;
  localparam logic [7:0] OFS_IFACE    = 8'h0c;
  localparam logic [7:0] OFS_WATER    = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1c;

  // Field positions: each decimal field takes one byte lane
  localparam int unsigned POS_HW    = 0;
  localparam int unsigned POS_OP    = 8;
  localparam int unsigned POS_TERM  = 0;
  localparam int unsigned POS_EOI   = 8;
  localparam int unsigned POS_ADDR  = 16;
  localparam int unsigned POS_VALVE = 24;
  localparam int unsigned POS_PEND  = 25;
  localparam int unsigned POS_CLR   = 0;

  // Legal encodings and ranges
  localparam logic [7:0] TERM_MAX   = 8'h03;
  localparam logic [7:0] TERM_NONE  = 8'h03;
  localparam logic [7:0] EOI_MAX    = 8'h01;
  localparam logic [7:0] ADDR_MIN   = 8'h01;
  localparam logic [7:0] ADDR_MAX   = 8'h1e;
  localparam logic [7:0] WMODE_MAX  = 8'h03;

  // Values after reset
  localparam logic [1:0] TERM_RST   = 2'h0;
  localparam logic       EOI_RST    = 1'b0;
  localparam logic [4:0] ADDR_RST   = 5'h0c;
  localparam logic [7:0] MASK_RST   = 8'h00;

  // Automatic valve thresholds (open level, shut level)
  localparam logic [15:0] PWR_OPEN  = 16'h0800;
  localparam logic [15:0] PWR_SHUT  = 16'h0600;
  localparam logic [15:0] TEMP_OPEN = 16'h0400;
  localparam logic [15:0] TEMP_SHUT = 16'h0380;

  // Interrupt status bits
  localparam int unsigned IRQ_W       = 4;
  localparam int unsigned IRQ_HW_ERR  = 0;
  localparam int unsigned IRQ_OP_ERR  = 1;
  localparam int unsigned IRQ_REJECT  = 2;
  localparam int unsigned IRQ_APPLIED = 3;

  // One error group pair, hardware byte and operational byte
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] hw;
  } esbc_err_t;

  // Bus interface settings
  typedef struct packed {
    logic [4:0] addr;
    logic       eoi_off;
    logic [1:0] term;
  } esbc_iface_t;

  typedef enum logic [1:0] {
    WMODE_OFF  = 2'b00,
    WMODE_ON   = 2'b01,
    WMODE_AUTO = 2'b10,
    WMODE_DIS  = 2'b11
  } esbc_wmode_t;

  typedef enum logic {
    VALVE_SHUT = 1'b0,
    VALVE_OPEN = 1'b1
  } esbc_valve_t;

endpackage : esbc_pkg

//--- rtl/esbc_core.sv
// Error status, bus interface settings and cooling valve, APB slave.
// Assumes a command parser on pclk that pulses cmd_end after each
// command's terminator, and error condition lines from outside pins.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module esbc_core
  import esbc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Error condition pins
  input  wire logic [7:0]  hw_err_pin,
  input  wire logic [7:0]  op_err_pin,
  // Command parser
  input  wire logic        cmd_end,
  // Cooling measurements and valve
  input  wire logic [15:0] power_meas,
  input  wire logic [15:0] temp_meas,
  output logic             valve_open,
  // Status outputs
  output logic             hw_summary,
  output logic             op_summary,
  output esbc_iface_t      iface_active,
  output logic             irq
);

  // Bus phases
  logic setup;
  logic wr_acc;
  logic rd_acc;

  // Synchronised error conditions
  esbc_err_t cond;

  // Stored state
  esbc_err_t   mask_q;
  esbc_err_t   latch_q;
  esbc_err_t   latch_d;
  esbc_err_t   rep_q;
  esbc_iface_t pend_q;
  logic        pend_flag_q;
  esbc_iface_t active_q;
  esbc_wmode_t wmode_q;
  esbc_valve_t valve_q;
  logic        valve_out_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_evt;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        sum_hw_q;
  logic        sum_op_q;

  // Write-field decode
  logic [7:0]  wr_term;
  logic [7:0]  wr_eoi;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_wmode;
  logic        iface_ok;
  logic        wmode_ok;
  logic        addr_hit;
  logic        bad_wr;
  logic        wr_iface_good;
  logic        wr_wmode_good;
  logic        hot;
  logic        cool;

  // Pin conditions pass the three-stage filter
  esbc_sync #(
    .W (8)
  ) u_sync_hw (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (hw_err_pin),
    .dout  (cond.hw)
  );

  esbc_sync #(
    .W (8)
  ) u_sync_op (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (op_err_pin),
    .dout  (cond.op)
  );

  // APB phases; every access completes with no wait state
  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign pready = psel & penable;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // Each decimal field sits in its own byte so bad values are visible
  assign wr_term  = pwdata[POS_TERM +: 8];
  assign wr_eoi   = pwdata[POS_EOI  +: 8];
  assign wr_addr  = pwdata[POS_ADDR +: 8];
  assign wr_wmode = pwdata[7:0];

  // Legal settings check
  always_comb begin
    iface_ok = (wr_term <= TERM_MAX) && (wr_eoi <= EOI_MAX);
    if ((wr_term == TERM_NONE) && (wr_eoi != 8'h00)) begin
      iface_ok = 1'b0;
    end
    if ((wr_addr < ADDR_MIN) || (wr_addr > ADDR_MAX)) begin
      iface_ok = 1'b0;
    end
    wmode_ok = (wr_wmode <= WMODE_MAX);
  end

  // Address map decode and write rejection
  always_comb begin
    case (paddr)
      OFS_ERR_EN, OFS_ERR_LAT, OFS_ERR_CLR, OFS_IFACE,
      OFS_WATER, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_STATUS: begin
        addr_hit = 1'b1;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
    bad_wr = pwrite &&
             (((paddr == OFS_IFACE) && !iface_ok) ||
              ((paddr == OFS_WATER) && !wmode_ok));
  end

  assign wr_iface_good = wr_acc && (paddr == OFS_IFACE) && iface_ok;
  assign wr_wmode_good = wr_acc && (paddr == OFS_WATER) && wmode_ok;

  // Read data and error are captured in setup so they come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      rep_q     <= '0;
    end else if (setup) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= !addr_hit || bad_wr;
      rep_q     <= '0;
      if (!pwrite) begin
        case (paddr)
          OFS_ERR_EN: begin
            prdata_q[POS_HW +: 8] <= mask_q.hw;
            prdata_q[POS_OP +: 8] <= mask_q.op;
          end
          OFS_ERR_LAT: begin
            prdata_q[POS_HW +: 8] <= latch_q.hw;
            prdata_q[POS_OP +: 8] <= latch_q.op;
            rep_q                 <= latch_q;
          end
          OFS_IFACE: begin
            prdata_q[POS_TERM +: 8] <= {6'h00, pend_q.term};
            prdata_q[POS_EOI  +: 8] <= {7'h00, pend_q.eoi_off};
            prdata_q[POS_ADDR +: 8] <= {3'h0, pend_q.addr};
          end
          OFS_WATER: begin
            prdata_q[7:0] <= {6'h00, wmode_q};
          end
          OFS_IRQ_STAT: begin
            prdata_q[IRQ_W-1:0] <= irq_stat_q;
          end
          OFS_IRQ_MASK: begin
            prdata_q[IRQ_W-1:0] <= irq_mask_q;
          end
          OFS_STATUS: begin
            prdata_q[POS_TERM +: 8] <= {6'h00, active_q.term};
            prdata_q[POS_EOI  +: 8] <= {7'h00, active_q.eoi_off};
            prdata_q[POS_ADDR +: 8] <= {3'h0, active_q.addr};
            prdata_q[POS_VALVE]     <= valve_out_q;
            prdata_q[POS_PEND]      <= pend_flag_q;
          end
          default: begin
            prdata_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Enable masks, hardware byte low and operational byte high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q.hw <= MASK_RST;
      mask_q.op <= MASK_RST;
    end else if (wr_acc && (paddr == OFS_ERR_EN)) begin
      mask_q.hw <= pwdata[POS_HW +: 8];
      mask_q.op <= pwdata[POS_OP +: 8];
    end
  end

  // Latched errors: clears first, detection last so a set always wins
  always_comb begin
    latch_d = latch_q;
    if (rd_acc && (paddr == OFS_ERR_LAT)) begin
      // Only bits already reported are cleared; later ones survive
      latch_d = latch_q & ~rep_q;
    end
    if (wr_acc && (paddr == OFS_ERR_CLR) && pwdata[POS_CLR]) begin
      // Bits whose condition persists stay set
      latch_d.op = latch_d.op & cond.op;
    end
    latch_d = latch_d | cond;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= '0;
    end else begin
      latch_q <= latch_d;
    end
  end

  // Summary bits pass only enabled errors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_hw_q <= 1'b0;
      sum_op_q <= 1'b0;
    end else begin
      sum_hw_q <= |(latch_q.hw & mask_q.hw);
      sum_op_q <= |(latch_q.op & mask_q.op);
    end
  end

  assign hw_summary = sum_hw_q;
  assign op_summary = sum_op_q;

  // Accepted settings wait here until the carrying command ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q.term    <= TERM_RST;
      pend_q.eoi_off <= EOI_RST;
      pend_q.addr    <= ADDR_RST;
    end else if (wr_iface_good) begin
      pend_q.term    <= wr_term[1:0];
      pend_q.eoi_off <= wr_eoi[0];
      pend_q.addr    <= wr_addr[4:0];
    end
  end

  // Pending flag; a new write in the end cycle stays pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_flag_q <= 1'b0;
    end else if (wr_iface_good) begin
      pend_flag_q <= 1'b1;
    end else if (cmd_end) begin
      pend_flag_q <= 1'b0;
    end
  end

  // Old terminator serves until the command end, then the swap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q.term    <= TERM_RST;
      active_q.eoi_off <= EOI_RST;
      active_q.addr    <= ADDR_RST;
    end else if (cmd_end && pend_flag_q) begin
      active_q <= pend_q;
    end
  end

  assign iface_active = active_q;

  // Water mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wmode_q <= WMODE_OFF;
    end else if (wr_wmode_good) begin
      wmode_q <= esbc_wmode_t'(wr_wmode[1:0]);
    end
  end

  // Hysteresis keeps the valve from chattering near one threshold
  assign hot  = (power_meas >= PWR_OPEN) || (temp_meas >= TEMP_OPEN);
  assign cool = (power_meas < PWR_SHUT) && (temp_meas < TEMP_SHUT);

  // Automatic valve state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valve_q <= VALVE_SHUT;
    end else begin
      case (valve_q)
        VALVE_SHUT: begin
          if (hot) begin
            valve_q <= VALVE_OPEN;
          end
        end
        VALVE_OPEN: begin
          if (cool) begin
            valve_q <= VALVE_SHUT;
          end
        end
        default: begin
          valve_q <= VALVE_SHUT;
        end
      endcase
    end
  end

  // Valve drive by mode; disabled mode leaves it shut
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valve_out_q <= 1'b0;
    end else begin
      case (wmode_q)
        WMODE_OFF: begin
          valve_out_q <= 1'b0;
        end
        WMODE_ON: begin
          valve_out_q <= 1'b1;
        end
        WMODE_AUTO: begin
          valve_out_q <= (valve_q == VALVE_OPEN);
        end
        default: begin
          valve_out_q <= 1'b0;
        end
      endcase
    end
  end

  assign valve_open = valve_out_q;

  // Interrupt events: new error latched, write refused, settings swapped
  always_comb begin
    irq_evt              = '0;
    irq_evt[IRQ_HW_ERR]  = |(cond.hw & ~latch_q.hw);
    irq_evt[IRQ_OP_ERR]  = |(cond.op & ~latch_q.op);
    irq_evt[IRQ_REJECT]  = wr_acc && bad_wr;
    irq_evt[IRQ_APPLIED] = cmd_end && pend_flag_q;
  end

  // Sticky status, write one to clear; an event in that cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else if (wr_acc && (paddr == OFS_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_q <= irq_stat_q | irq_evt;
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= '0;
    end else if (wr_acc && (paddr == OFS_IRQ_MASK)) begin
      irq_mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  // Level interrupt while any enabled status bit is set
  assign irq = |(irq_stat_q & irq_mask_q);

endmodule : esbc_core

//--- rtl/esbc_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes asynchronous inputs; output moves when stages two and three agree.
`timescale 1ns/1ps
module esbc_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pin side and clean side
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Hold a bit whose last two stages still disagree
      dout <= (s3_q & ~(s2_q ^ s3_q)) | (dout & (s2_q ^ s3_q));
    end
  end

endmodule : esbc_sync

//--- testbench/esbc_core_monitor.sv
// Port-level checker for the error status and bus config core.
// Assumes one pclk domain; attached by bind below.
`timescale 1ns/1ps
module esbc_core_monitor
  import esbc_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Status and command end
  input wire logic        cmd_end,
  input wire logic        hw_summary,
  input wire logic        op_summary,
  input wire esbc_iface_t iface_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Zero wait states, so every access is answered at once
  chk_no_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  // Settings in use move only at the end of a command
  chk_active_hold: assert property (!cmd_end |=> $stable(iface_active))
    else $error("active settings moved without command end");
  chk_addr_range: assert property (iface_active.addr inside {[1:30]})
    else $error("active address out of range");
  chk_term_eoi: assert property (iface_active.term == 2'h3 |-> !iface_active.eoi_off)
    else $error("no terminator with EOI off");
  // Latched errors hold while nobody touches the bus
  chk_hw_sticky: assert property (hw_summary && !psel && !$past(psel)
    && !$past(psel, 2) |=> hw_summary)
    else $error("hw summary dropped without access");
  chk_op_sticky: assert property ($fell(op_summary) |->
    $past(psel) || $past(psel, 2) || $past(psel, 3))
    else $error("op summary dropped without access");
  // Unmapped places answer with an error and zero data
  chk_bad_err: assert property (psel && !penable && paddr > 8'h1c
    |=> pslverr)
    else $error("no error on unmapped address");
  chk_bad_data: assert property (psel && !penable && !$past(presetn) == 1'b0
    && paddr > 8'h1c |=> prdata == 32'h0)
    else $error("data on unmapped address");
endmodule : esbc_core_monitor

bind esbc_core esbc_core_monitor esbc_core_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmd_end(cmd_end), .hw_summary(hw_summary), .op_summary(op_summary),
  .iface_active(iface_active)
);

//--- testbench/esbc_core_tb.sv
// Self-checking bench for the error status and bus config core.
// Assumes zero-wait APB and the parser model for command ends.
`timescale 1ns/1ps
module esbc_core_tb;
  import esbc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, cmd_end, end_req;
  logic        pready, pslverr, valve_open, hw_summary, op_summary, irq;
  logic [7:0]  paddr, hw_err_pin, op_err_pin;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] power_meas, temp_meas;
  logic        er;
  esbc_iface_t iface_active;
  int          fail_count, check_count;

  esbc_core esbc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_err_pin(hw_err_pin), .op_err_pin(op_err_pin), .cmd_end(cmd_end),
    .power_meas(power_meas), .temp_meas(temp_meas), .valve_open(valve_open),
    .hw_summary(hw_summary), .op_summary(op_summary),
    .iface_active(iface_active), .irq(irq));
  esbc_parser_model esbc_parser_model_inst (.pclk(pclk), .presetn(presetn),
    .end_req(end_req), .cmd_end(cmd_end));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; only the watchdog ends a wait for pready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer

  task automatic pins(input logic [7:0] h, input logic [7:0] o);
    hw_err_pin <= h; op_err_pin <= o;
    repeat (10) @(posedge pclk);
  endtask : pins

  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    $display("FAIL %0t watchdog expired", $time);
    finish_test;
  end

  initial begin
    logic [31:0] bad [5];
    bad = '{32'h000c0004, 32'h000c0103, 32'h0, 32'h001f0000, 32'h000c0200};
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; end_req = 1'b0; hw_err_pin = 8'h0;
    op_err_pin = 8'h0; power_meas = 16'h0; temp_meas = 16'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    xfer(0, OFS_IFACE, 0); chk(rd, 32'h000c0000);
    xfer(0, OFS_ERR_EN, 0); chk(rd, 32'h0);
    chk(32'(iface_active), 32'h60);
    $display("test reset done");
    // Masks, latching and read clear
    xfer(1, OFS_ERR_EN, 32'h0000a505);
    xfer(0, OFS_ERR_EN, 0); chk(rd, 32'h0000a505);
    pins(8'h04, 8'h10); pins(8'h0, 8'h0);
    chk(32'(hw_summary), 32'h1);
    chk(32'(op_summary), 32'h0);
    xfer(0, OFS_ERR_LAT, 0); chk(rd, 32'h00001004);
    xfer(0, OFS_ERR_LAT, 0); chk(rd, 32'h0);
    $display("test latch done");
    // Clear command: hw kept, op kept only where still present
    pins(8'h01, 8'h30); pins(8'h0, 8'h20);
    xfer(1, OFS_ERR_CLR, 32'h1);
    xfer(0, OFS_ERR_LAT, 0); chk(rd, 32'h00002001);
    pins(8'h0, 8'h0);
    xfer(0, OFS_ERR_LAT, 0); chk(rd, 32'h00002000);
    $display("test clear done");
    // New settings wait for the end of the command
    xfer(1, OFS_IFACE, 32'h00040102); chk(32'(er), 32'h0);
    xfer(0, OFS_IFACE, 0); chk(rd, 32'h00040102);
    chk(32'(iface_active), 32'h60);
    end_req <= 1'b1;
    @(posedge pclk);
    end_req <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'(iface_active), 32'h26);
    xfer(0, OFS_STATUS, 0); chk(rd, 32'h00040102);
    // Illegal values refused, old value kept
    foreach (bad[i]) begin
      xfer(1, OFS_IFACE, bad[i]); chk(32'(er), 32'h1);
      xfer(0, OFS_IFACE, 0); chk(rd, 32'h00040102);
    end
    xfer(1, OFS_IFACE, 32'h001e0003); chk(32'(er), 32'h0);
    $display("test iface done");
    // Water modes, forced and automatic valve
    for (int m = 0; m < 4; m++) begin
      xfer(1, OFS_WATER, 32'(m));
      xfer(0, OFS_WATER, 0); chk(rd, 32'(m));
    end
    xfer(1, OFS_WATER, 32'h4); chk(32'(er), 32'h1);
    xfer(1, OFS_WATER, 32'h1); repeat (3) @(posedge pclk);
    chk(32'(valve_open), 32'h1);
    xfer(1, OFS_WATER, 32'h2); repeat (3) @(posedge pclk);
    chk(32'(valve_open), 32'h0);
    power_meas <= 16'h0900; repeat (3) @(posedge pclk);
    chk(32'(valve_open), 32'h1);
    power_meas <= 16'h0; repeat (3) @(posedge pclk);
    chk(32'(valve_open), 32'h0);
    temp_meas <= 16'h0400; repeat (3) @(posedge pclk);
    chk(32'(valve_open), 32'h1);
    $display("test water done");
    // Interrupt on refused write: mask, then clear
    chk(32'(irq), 32'h0);
    xfer(0, OFS_IRQ_STAT, 0); chk(rd, 32'h0000000f);
    xfer(1, OFS_IRQ_MASK, 32'h4); @(posedge pclk);
    chk(32'(irq), 32'h1);
    xfer(1, OFS_IRQ_STAT, 32'h4); @(posedge pclk);
    chk(32'(irq), 32'h0);
    xfer(0, OFS_IRQ_STAT, 0); chk(rd, 32'h0000000b);
    xfer(0, 8'h40, 0); chk(rd, 32'h0);
    chk(32'(er), 32'h1);
    $display("test irq done");
    finish_test;
  end
endmodule : esbc_core_tb

//--- testbench/esbc_parser_model.sv
// Model of the command parser: ends a command some cycles after a request.
// Assumes end_req is a one-cycle pulse on pclk.
`timescale 1ns/1ps
module esbc_parser_model #(
  parameter int unsigned DLY = 3
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Request and command end pulse
  input  wire logic end_req,
  output logic      cmd_end
);
  logic [3:0] cnt_q;

  // Terminator takes a few cycles to arrive, so the pulse is late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 4'h0;
      cmd_end <= 1'b0;
    end else begin
      cmd_end <= (cnt_q == 4'h1);
      if (end_req) cnt_q <= 4'(DLY);
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule : esbc_parser_model
